/* fbc_bus_cycle.v */
`include "fbc_consts.vh"
`default_nettype none
// ****************************************
// One bus cycle on the flash pins
// ****************************************
module fbc_bus_cycle (
   input wire i_core_clk,
   input wire i_rst_n,
   input wire i_ce,
   input wire i_start,
   input wire i_write,
   input wire [21:0] i_addr,
   input wire [15:0] i_wdata,
   input wire [15:0] i_dq_in,
   output reg o_done,
   output reg [15:0] o_rdata,
   output reg [21:0] o_fa,
   output reg [15:0] o_dq_out,
   output reg o_dq_oe,
   output reg o_we_n,
   output reg o_oe_n,
   output reg o_ce_n
);
   localparam ST_IDLE = 2'h0;
   localparam ST_SETUP = 2'h1;
   localparam ST_PULSE = 2'h2;
   localparam ST_HOLD = 2'h3;
   reg [1:0] st_r;
   reg [3:0] cnt_r;
   reg wr_r;
   // Address stable before strobe falls, data held past rising strobe
   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_r <= ST_IDLE;
         cnt_r <= 4'h0;
         wr_r <= 1'b0;
         o_done <= 1'b0;
         o_rdata <= 16'h0000;
         o_fa <= 22'h000000;
         o_dq_out <= 16'h0000;
         o_dq_oe <= 1'b0;
         o_we_n <= 1'b1;
         o_oe_n <= 1'b1;
         o_ce_n <= 1'b1;
      end else if (i_ce) begin
         o_done <= 1'b0;
         case (st_r)
            ST_IDLE: begin
               if (i_start) begin
                  o_fa <= i_addr;
                  o_dq_out <= i_wdata;
                  o_dq_oe <= i_write;
                  wr_r <= i_write;
                  cnt_r <= `FBC_T_SETUP;
                  st_r <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               if (cnt_r == 4'h1) begin
                  o_ce_n <= 1'b0;
                  o_we_n <= ~wr_r;
                  o_oe_n <= wr_r;
                  cnt_r <= wr_r ? `FBC_T_PULSE : `FBC_T_READ;
                  st_r <= ST_PULSE;
               end else begin
                  cnt_r <= cnt_r - 4'h1;
               end
            end
            ST_PULSE: begin
               if (cnt_r == 4'h1) begin
                  o_rdata <= i_dq_in;
                  o_we_n <= 1'b1;
                  o_oe_n <= 1'b1;
                  o_ce_n <= 1'b1;
                  cnt_r <= `FBC_T_HOLD;
                  st_r <= ST_HOLD;
               end else begin
                  cnt_r <= cnt_r - 4'h1;
               end
            end
            ST_HOLD: begin
               if (cnt_r == 4'h1) begin
                  o_dq_oe <= 1'b0;
                  o_done <= 1'b1;
                  st_r <= ST_IDLE;
               end else begin
                  cnt_r <= cnt_r - 4'h1;
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end
endmodule // fbc_bus_cycle
`default_nettype wire

/* fbc_consts.vh */
`ifndef FBC_CONSTS_VH
`define FBC_CONSTS_VH
// APB register byte offsets
`define FBC_REG_CTRL 8'h00
`define FBC_REG_ADDR 8'h04
`define FBC_REG_DATA 8'h08
`define FBC_REG_STAT 8'h0C
`define FBC_REG_RDAT 8'h10
// Control register fields
`define FBC_CTRL_GO 0
`define FBC_CTRL_CMD_LSB 4
`define FBC_CTRL_CMD_MSB 7
`define FBC_CTRL_ACC 8
// Operation codes written to the control register
`define FBC_OP_READ 4'h0
`define FBC_OP_RESET 4'h1
`define FBC_OP_AUTOSEL 4'h2
`define FBC_OP_SEC_ENTER 4'h3
`define FBC_OP_SEC_EXIT 4'h4
`define FBC_OP_PROGRAM 4'h5
`define FBC_OP_BYP_ENTER 4'h6
`define FBC_OP_BYP_PROG 4'h7
`define FBC_OP_BYP_RESET 4'h8
// Flash command words
`define FBC_UNLK1_ADDR 22'h000555
`define FBC_UNLK1_DATA 16'h00AA
`define FBC_UNLK2_ADDR 22'h0002AA
`define FBC_UNLK2_DATA 16'h0055
`define FBC_CMD_RESET 16'h00F0
`define FBC_CMD_AUTOSEL 16'h0090
`define FBC_CMD_SEC_ENTER 16'h0088
`define FBC_CMD_SEC_EXIT 16'h0090
`define FBC_CMD_SEC_EXIT2 16'h0000
`define FBC_CMD_PROGRAM 16'h00A0
`define FBC_CMD_BYPASS 16'h0020
`define FBC_CMD_BYP_RST1 16'h0090
`define FBC_CMD_BYP_RST2 16'h0000
// Bus cycle timing in core clocks
`define FBC_T_SETUP 4'h2
`define FBC_T_PULSE 4'h5
`define FBC_T_HOLD 4'h2
`define FBC_T_READ 4'h8
// Widths
`define FBC_AW 22
`define FBC_DW 16
`endif

/* fbc_ctrl.v */
// Operation
// - Bad sequence needs reset command
// - Host resets after timeout flag or autoselect
// - Autoselect only while no bank busy
// - Autoselect: two unlocks plus bank command
// - Protection read needs bank and sector
// - Secure region: three in, four out
// - Program: unlocks, setup, address with data
// - Bypass entry: unlocks then 20h
// - Bypass: A0h then address, two-cycle exit
//
// Implementation choices: the APB slave port and the register offsets.
`include "fbc_consts.vh"
`default_nettype none
module fbc_ctrl (
   input wire i_core_clk,
   input wire i_rst_n,
   input wire i_ce,
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [7:0] i_paddr,
   input wire [31:0] i_pwdata,
   output reg [31:0] o_prdata,
   output reg o_pready,
   output reg o_pslverr,
   input wire [15:0] i_dq_in,
   input wire i_ready_busy_output,
   output wire [21:0] o_fa,
   output wire [15:0] o_dq_out,
   output wire o_dq_oe,
   output wire o_we_n,
   output wire o_oe_n,
   output wire o_ce_n,
   output reg o_acc_hv
);
   // ****************************************
   // Registers and state
   // ****************************************
   localparam ST_IDLE = 3'h0;
   localparam ST_ISSUE = 3'h1;
   localparam ST_WAIT = 3'h2;
   localparam ST_POLL = 3'h3;
   localparam ST_PWAIT = 3'h4;
   reg [2:0] st_r;
   reg [3:0] op_r;
   reg [2:0] step_r;
   reg [21:0] addr_r;
   reg [15:0] data_r;
   reg [15:0] rdat_r;
   reg busy_r, err_r, secure_r, bypass_r, autosel_r;
   reg [2:0] ry_sync_r;
   reg ry_r;
   reg cyc_start_r, cyc_wr_r;
   reg [21:0] cyc_addr_r;
   reg [15:0] cyc_data_r;
   wire cyc_done;
   wire [15:0] cyc_rdata;
   wire [3:0] nsteps;
   wire last_step;

   fbc_bus_cycle u_cyc (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_ce(i_ce),
      .i_start(cyc_start_r),
      .i_write(cyc_wr_r),
      .i_addr(cyc_addr_r),
      .i_wdata(cyc_data_r),
      .i_dq_in(i_dq_in),
      .o_done(cyc_done),
      .o_rdata(cyc_rdata),
      .o_fa(o_fa),
      .o_dq_out(o_dq_out),
      .o_dq_oe(o_dq_oe),
      .o_we_n(o_we_n),
      .o_oe_n(o_oe_n),
      .o_ce_n(o_ce_n)
   );

   // Cycle count of each operation
   assign nsteps = (op_r == `FBC_OP_READ) ? 4'h1 :
                   (op_r == `FBC_OP_RESET) ? 4'h1 :
                   (op_r == `FBC_OP_AUTOSEL) ? 4'h3 :
                   (op_r == `FBC_OP_SEC_ENTER) ? 4'h3 :
                   (op_r == `FBC_OP_SEC_EXIT) ? 4'h4 :
                   (op_r == `FBC_OP_PROGRAM) ? 4'h4 :
                   (op_r == `FBC_OP_BYP_ENTER) ? 4'h3 :
                   4'h2;
   assign last_step = ({1'b0, step_r} == nsteps - 4'h1);

   // ****************************************
   // Address and data of each sequence step
   // ****************************************
   always @* begin
      cyc_wr_r = 1'b1;
      cyc_addr_r = addr_r;
      cyc_data_r = data_r;
      if (op_r == `FBC_OP_READ) begin
         cyc_wr_r = 1'b0;
      end else if (op_r == `FBC_OP_RESET) begin
         cyc_data_r = `FBC_CMD_RESET;
      end else if (op_r == `FBC_OP_BYP_PROG) begin
         cyc_data_r = (step_r == 3'h0) ? `FBC_CMD_PROGRAM : data_r;
      end else if (op_r == `FBC_OP_BYP_RESET) begin
         cyc_data_r = (step_r == 3'h0) ? `FBC_CMD_BYP_RST1 : `FBC_CMD_BYP_RST2;
      end else if (step_r == 3'h0) begin
         cyc_addr_r = `FBC_UNLK1_ADDR;
         cyc_data_r = `FBC_UNLK1_DATA;
      end else if (step_r == 3'h1) begin
         cyc_addr_r = `FBC_UNLK2_ADDR;
         cyc_data_r = `FBC_UNLK2_DATA;
      end else if (step_r == 3'h2) begin
         cyc_addr_r = (op_r == `FBC_OP_AUTOSEL) ? addr_r : `FBC_UNLK1_ADDR;
         case (op_r)
            `FBC_OP_AUTOSEL: cyc_data_r = `FBC_CMD_AUTOSEL;
            `FBC_OP_SEC_ENTER: cyc_data_r = `FBC_CMD_SEC_ENTER;
            `FBC_OP_SEC_EXIT: cyc_data_r = `FBC_CMD_SEC_EXIT;
            `FBC_OP_PROGRAM: cyc_data_r = `FBC_CMD_PROGRAM;
            default: cyc_data_r = `FBC_CMD_BYPASS;
         endcase
      end else begin
         cyc_data_r = (op_r == `FBC_OP_SEC_EXIT) ? `FBC_CMD_SEC_EXIT2 : data_r;
      end
   end

   // ****************************************
   // Sequencer and APB slave
   // ****************************************
   // Program completion is tracked through the ready pin, so no polling loop on status bits
   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_r <= ST_IDLE;
         op_r <= `FBC_OP_READ;
         step_r <= 3'h0;
         addr_r <= 22'h000000;
         data_r <= 16'h0000;
         rdat_r <= 16'h0000;
         busy_r <= 1'b0;
         err_r <= 1'b0;
         secure_r <= 1'b0;
         bypass_r <= 1'b0;
         autosel_r <= 1'b0;
         ry_sync_r <= 3'h7; // Idle level of the ready pin, so no false busy after reset
         ry_r <= 1'b1;
         cyc_start_r <= 1'b0;
         o_prdata <= 32'h00000000;
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_acc_hv <= 1'b0;
      end else if (i_ce) begin
         ry_sync_r <= {ry_sync_r[1:0], i_ready_busy_output};
         if (ry_sync_r[2] == ry_sync_r[1]) begin
            ry_r <= ry_sync_r[2];
         end
         cyc_start_r <= 1'b0;
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         // APB access, one wait state
         if (i_psel && i_penable && !o_pready) begin
            o_pready <= 1'b1;
            o_prdata <= 32'h00000000;
            if (i_pwrite) begin
               case (i_paddr)
                  `FBC_REG_CTRL: begin
                     o_acc_hv <= i_pwdata[`FBC_CTRL_ACC] & ~secure_r;
                     if (i_pwdata[`FBC_CTRL_GO]) begin
                        if (busy_r) begin
                           err_r <= 1'b1;
                        end else begin
                           op_r <= i_pwdata[`FBC_CTRL_CMD_MSB:`FBC_CTRL_CMD_LSB];
                           step_r <= 3'h0;
                           busy_r <= 1'b1;
                           err_r <= 1'b0;
                           st_r <= ST_ISSUE;
                        end
                     end
                  end
                  `FBC_REG_ADDR: addr_r <= i_pwdata[21:0];
                  `FBC_REG_DATA: data_r <= i_pwdata[15:0];
                  default: o_pslverr <= 1'b1;
               endcase
            end else begin
               case (i_paddr)
                  `FBC_REG_CTRL: o_prdata <= {23'h000000, o_acc_hv, op_r, 4'h0};
                  `FBC_REG_ADDR: o_prdata <= {10'h000, addr_r};
                  `FBC_REG_DATA: o_prdata <= {16'h0000, data_r};
                  `FBC_REG_STAT: o_prdata <= {26'h0000000, ry_r, autosel_r, bypass_r,
                                              secure_r, err_r, busy_r};
                  `FBC_REG_RDAT: o_prdata <= {16'h0000, rdat_r};
                  default: o_pslverr <= 1'b1;
               endcase
            end
         end
         case (st_r)
            ST_IDLE: ;
            ST_ISSUE: begin
               if ((op_r == `FBC_OP_AUTOSEL && !ry_r) ||
                   (op_r == `FBC_OP_BYP_ENTER && secure_r) ||
                   (op_r > `FBC_OP_BYP_RESET)) begin
                  err_r <= 1'b1;
                  busy_r <= 1'b0;
                  st_r <= ST_IDLE;
               end else begin
                  cyc_start_r <= 1'b1;
                  st_r <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (cyc_done) begin
                  if (!last_step) begin
                     step_r <= step_r + 3'h1;
                     st_r <= ST_ISSUE;
                  end else begin
                     rdat_r <= cyc_rdata;
                     case (op_r)
                        `FBC_OP_RESET: begin
                           autosel_r <= 1'b0;
                        end
                        `FBC_OP_AUTOSEL: autosel_r <= 1'b1;
                        `FBC_OP_SEC_ENTER: begin
                           secure_r <= 1'b1;
                           o_acc_hv <= 1'b0;
                        end
                        `FBC_OP_SEC_EXIT: secure_r <= 1'b0;
                        `FBC_OP_BYP_ENTER: bypass_r <= 1'b1;
                        `FBC_OP_BYP_RESET: bypass_r <= 1'b0;
                        default: ;
                     endcase
                     if (op_r == `FBC_OP_PROGRAM || op_r == `FBC_OP_BYP_PROG) begin
                        st_r <= ST_POLL;
                     end else begin
                        busy_r <= 1'b0;
                        st_r <= ST_IDLE;
                     end
                  end
               end
            end
            ST_POLL: begin
               if (!ry_r) begin
                  st_r <= ST_PWAIT;
               end
            end
            ST_PWAIT: begin
               if (ry_r) begin
                  busy_r <= 1'b0;
                  st_r <= ST_IDLE;
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end
endmodule // fbc_ctrl
`default_nettype wire

/* fbc_ctrl_sva.sv */
`default_nettype none
// ********************
// Pin and APB timing checks
// ********************
module fbc_ctrl_chk (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic [21:0] o_fa,
   input wire logic [15:0] o_dq_out,
   input wire logic o_dq_oe,
   input wire logic o_we_n,
   input wire logic o_oe_n,
   input wire logic o_ce_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_n);
   sequence s_taken;
      i_psel && i_penable && !o_pready && i_ce;
   endsequence
   sequence s_we_low;
      !o_we_n [*5];
   endsequence
   sequence s_oe_low;
      !o_oe_n [*8];
   endsequence
   property p_answer;
      s_taken |=> o_pready;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer after one wait state");
   property p_pulse;
      o_pready |=> !o_pready;
   endproperty
   a_pulse: assert property (p_pulse) else $error("ready held over one cycle");
   property p_cause;
      o_pready |-> $past(i_penable) && i_psel;
   endproperty
   a_cause: assert property (p_cause) else $error("ready without request");
   property p_err;
      o_pslverr |-> o_pready;
   endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_wr_len;
      $fell(o_we_n) |-> s_we_low ##1 o_we_n;
   endproperty
   a_wr_len: assert property (p_wr_len) else $error("write strobe length");
   property p_wr_sel;
      !o_we_n |-> !o_ce_n && o_oe_n && o_dq_oe;
   endproperty
   a_wr_sel: assert property (p_wr_sel) else $error("write strobe unqualified");
   property p_wr_stable;
      !o_we_n ##1 !o_we_n |-> $stable(o_fa) && $stable(o_dq_out);
   endproperty
   a_wr_stable: assert property (p_wr_stable) else $error("bus moved in strobe");
   property p_wr_hold;
      $rose(o_we_n) |-> (o_dq_oe && $stable(o_dq_out) && $stable(o_fa)) [*2];
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write hold too short");
   property p_rd_len;
      $fell(o_oe_n) |-> s_oe_low ##1 o_oe_n;
   endproperty
   a_rd_len: assert property (p_rd_len) else $error("read strobe length");
   property p_rd_free;
      !o_oe_n |-> !o_dq_oe && !o_ce_n;
   endproperty
   a_rd_free: assert property (p_rd_free) else $error("drive during read");
endmodule // fbc_ctrl_chk
bind fbc_ctrl fbc_ctrl_chk u_chk (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
   .i_psel(i_psel), .i_penable(i_penable), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .o_fa(o_fa), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe), .o_we_n(o_we_n), .o_oe_n(o_oe_n),
   .o_ce_n(o_ce_n));
`default_nettype wire

/* fbc_flash_model.sv */
`default_nettype none
// ********************
// Behavioural flash bank
// ********************
module fbc_flash_model #(
   parameter logic [15:0] ID_WORD = 16'h1357, // Arbitrary identification value
   parameter logic [15:0] SEC_WORD = 16'h5EC0
) (
   input wire logic i_core_clk,
   input wire logic [21:0] i_fa,
   input wire logic [15:0] i_dq_out,
   input wire logic i_we_n,
   input wire logic i_oe_n,
   input wire logic i_ce_n,
   input wire logic i_acc_hv,
   output logic [15:0] o_dq_in,
   output logic o_ready_busy_output
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [0:15];
   logic [21:0] addr_r;
   logic asel = 0, secm = 0, byp = 0;
   int step = 0, busy = 0;
   wire strobe_n = i_we_n | i_ce_n;
   // Erased array, so only clearing shows after a program
   initial begin
      for (int i = 0; i < 16; i++) mem[i] = 16'hFFFF;
      o_dq_in = 16'h0;
   end
   always @(negedge strobe_n) addr_r = i_fa;
   // Command decode on the earlier rising edge
   always @(posedge strobe_n) begin : decode
      logic [15:0] d;
      d = i_dq_out;
      if (busy == 0) begin
         if (step == 3) begin
            mem[addr_r[3:0]] = mem[addr_r[3:0]] & d;
            busy = 40;
            step = 0;
         end else if ((byp || i_acc_hv) && !secm) begin
            if (d == 16'h00A0) step = 3;
            else if (step == 5 && d == 16'h0000) begin
               byp = 0;
               step = 0;
            end
            else step = (d == 16'h0090) ? 5 : 0;
         end else if (d == 16'h00F0) begin
            asel = 0;
            step = 0;
         end else if (step == 0 && addr_r == 22'h555 && d == 16'h00AA) step = 1;
         else if (step == 1 && addr_r == 22'h2AA && d == 16'h0055) step = 2;
         else if (step == 2) begin
            step = (d == 16'h00A0) ? 3 : (d == 16'h0090 && secm) ? 4 : 0;
            if (d == 16'h0090 && !secm) asel = 1;
            if (d == 16'h0088) secm = 1;
            if (d == 16'h0020 && !secm) byp = 1;
         end else if (step == 4 && d == 16'h0000) begin
            secm = 0;
            step = 0;
         end else step = 0;
      end
   end
   always @(posedge i_core_clk) if (busy > 0) busy <= busy - 1;
   assign o_ready_busy_output = (busy == 0);
   // Deselected bus flips every cycle so a stale word never passes
   always @(posedge i_core_clk) begin
      // No sector is ever erase-suspended here, so plain reads give array data
      if (!i_oe_n && !i_ce_n) begin
         o_dq_in <= asel ? ID_WORD : secm ? SEC_WORD : mem[i_fa[3:0]];
      end else begin
         o_dq_in <= ~o_dq_in;
      end
   end
endmodule // fbc_flash_model
`default_nettype wire

/* fbc_tb.sv */
`include "fbc_consts.vh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] ID = 16'h1357, SEC = 16'h5EC0;
   logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
   logic dq_oe, we_n, oe_n, ce_n, acc_hv, ready_busy_output;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic [21:0] fa, pa [3] = '{22'h9, 22'h2, 22'h3};
   logic [15:0] dq_out, dq_in, pd [3] = '{16'h1E3C, 16'h0F0F, 16'hA5C3};
   int n_errors = 0, check_count = 0;
   always #5 core_clk = ~core_clk;
   fbc_ctrl u_dut (.i_core_clk(core_clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_dq_in(dq_in),
      .i_ready_busy_output(ready_busy_output), .o_fa(fa), .o_dq_out(dq_out), .o_dq_oe(dq_oe), .o_we_n(we_n),
      .o_oe_n(oe_n), .o_ce_n(ce_n), .o_acc_hv(acc_hv));
   fbc_flash_model #(.ID_WORD(ID), .SEC_WORD(SEC)) u_flash (.i_core_clk(core_clk), .i_fa(fa),
      .i_dq_out(dq_out), .i_we_n(we_n), .i_oe_n(oe_n), .i_ce_n(ce_n), .i_acc_hv(acc_hv),
      .o_dq_in(dq_in), .o_ready_busy_output(ready_busy_output));
   // ********************
   // Bus tasks
   // ********************
   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Held until ready is seen, released only after that edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) n_errors++;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Poll the busy bit until the sequencer is free again
   task automatic wait_idle;
      int n;
      n = 0;
      do begin
         apb(1'b0, `FBC_REG_STAT, 32'h0);
         n++;
      end while (q[0] !== 1'b0 && n < 100);
      if (n >= 100) n_errors++;
   endtask
   task automatic op(input logic [3:0] c, input logic [21:0] a, input logic [15:0] d,
      input logic acc);
      apb(1'b1, `FBC_REG_ADDR, {10'h0, a});
      apb(1'b1, `FBC_REG_DATA, {16'h0, d});
      apb(1'b1, `FBC_REG_CTRL, {23'h0, acc, c, 4'h1});
      wait_idle();
   endtask
   task automatic rdf(input logic [21:0] a, input logic [15:0] exp);
      op(`FBC_OP_READ, a, 16'h0, 1'b0);
      apb(1'b0, `FBC_REG_RDAT, 32'h0);
      check("flash word", q, {16'h0, exp});
   endtask
   task automatic st(input int b, input logic exp);
      apb(1'b0, `FBC_REG_STAT, 32'h0);
      check("status bit", {31'h0, q[b]}, {31'h0, exp});
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ********************
   // Sequence
   // ********************
   initial begin
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      rdf(22'h3, 16'hFFFF);
      for (int i = 0; i < 3; i++) op(`FBC_OP_PROGRAM, pa[i], pd[i], 1'b0);
      for (int i = 0; i < 3; i++) rdf(pa[i], pd[i]);
      st(5, 1'b1);
      // Second GO lands while the first program is still busy
      apb(1'b1, `FBC_REG_ADDR, 32'h2);
      apb(1'b1, `FBC_REG_DATA, 32'hFF00);
      apb(1'b1, `FBC_REG_CTRL, {24'h0, `FBC_OP_PROGRAM, 4'h1});
      apb(1'b1, `FBC_REG_CTRL, {24'h0, `FBC_OP_RESET, 4'h1});
      st(1, 1'b1);
      // Address and data registers feed the running program, so let it finish first
      wait_idle();
      rdf(22'h2, 16'h0F00);
      $display("test program done");
      op(`FBC_OP_AUTOSEL, 22'h0, 16'h0, 1'b0);
      st(4, 1'b1);
      rdf(22'h3, ID);
      rdf(22'h9, ID);
      op(`FBC_OP_RESET, 22'h3FFFFF, 16'h0, 1'b0);
      st(4, 1'b0);
      rdf(22'h3, pd[2]);
      $display("test autoselect done");
      op(`FBC_OP_SEC_ENTER, 22'h0, 16'h0, 1'b0);
      st(2, 1'b1);
      rdf(22'h1, SEC);
      apb(1'b1, `FBC_REG_CTRL, 32'h00000100);
      apb(1'b0, `FBC_REG_CTRL, 32'h0);
      check("accelerate in secure", {31'h0, q[8]}, 32'h0);
      op(`FBC_OP_BYP_ENTER, 22'h0, 16'h0, 1'b0);
      st(3, 1'b0);
      op(`FBC_OP_SEC_EXIT, 22'h0, 16'h0, 1'b0);
      st(2, 1'b0);
      rdf(22'h9, pd[0]);
      $display("test secure done");
      op(`FBC_OP_BYP_ENTER, 22'h0, 16'h0, 1'b0);
      st(3, 1'b1);
      op(`FBC_OP_BYP_PROG, 22'h5, 16'h1234, 1'b0);
      rdf(22'h5, 16'h1234);
      op(`FBC_OP_BYP_RESET, 22'h0, 16'h0, 1'b0);
      st(3, 1'b0);
      op(`FBC_OP_BYP_PROG, 22'h6, 16'h0042, 1'b1);
      rdf(22'h6, 16'h0042);
      $display("test bypass done");
      apb(1'b0, 8'h20, 32'h0);
      check("unmapped error", {31'h0, e}, 32'h1);
      op(4'hF, 22'h0, 16'h0, 1'b0);
      st(1, 1'b1);
      $display("test unmapped done");
      wrap_up();
   end
   // Whole sequence needs a few thousand cycles
   initial begin
      repeat (30000) @(posedge core_clk);
      n_errors++;
      wrap_up();
   end
endmodule // testbench
`default_nettype wire
